// >>> design/phymc_pkg.sv
// constants, carrier types and state encodings for the mii carrier/collision block
package phymc_pkg;

	// ****************************************
	// clocks and bit times
	// ****************************************
	localparam int REF_HZ      = 40_000_000;
	localparam int REF_NS      = 25;
	localparam int BIT10_NS    = 100;
	localparam int NIB_BITS    = 4;

	// ****************************************
	// transmit carrier loopback, in bit times
	// ****************************************
	localparam int TXCRS_RISE  = 2;
	localparam int TXCRS_HOLD  = 2;

	// ****************************************
	// receive delimiters and pipeline depths
	// ****************************************
	localparam int          DLM_BITS = 10;
	localparam logic [9:0]  PAT_JK   = 10'h311;
	localparam logic [9:0]  PAT_TR   = 10'h1a7;
	localparam logic [3:0]  NIB_SD   = 4'h5;
	localparam logic [3:0]  NIB_IDLE = 4'h0;
	localparam int          RXD_DLY  = 6;
	localparam int          ED_DLY   = 4;

	// ****************************************
	// heartbeat, 10 mb/s only
	// ****************************************
	localparam int SQE_DLY_NS  = 850;
	localparam int SQE_LEN_NS  = 1000;
	localparam int SQE_MAX_NS  = 1500;
	localparam int SQE_DLY_CYC = SQE_DLY_NS / BIT10_NS;
	localparam int SQE_LEN_CYC = SQE_LEN_NS / BIT10_NS;
	localparam int SQE_MAX_CYC = SQE_MAX_NS / BIT10_NS;

	// ****************************************
	// reset sequencing
	// ****************************************
	localparam int POR_MS      = 45;
	localparam int RST_CLK_MS  = 35;
	localparam int POR_CYC     = POR_MS * (REF_HZ / 1000);
	localparam int RST_CLK_CYC = RST_CLK_MS * (REF_HZ / 1000);
	localparam int RST_MIN_NS  = 500;
	localparam int RST_MIN_CYC = (RST_MIN_NS + REF_NS - 1) / REF_NS;
	localparam int ISO_NS      = 60;
	localparam int ISO_CYC     = ISO_NS / REF_NS;

	// ****************************************
	// carriers and states
	// ****************************************
	typedef struct packed {
		logic crs;
		logic col;
	} phymc_stat_type;

	typedef struct packed {
		logic       dv;
		logic [3:0] d;
	} phymc_rx_type;

	typedef enum logic [1:0] {RS_POR, RS_READY, RS_INIT} phymc_rst_type;
	typedef enum logic [1:0] {SQ_IDLE, SQ_WAIT, SQ_PULSE} phymc_sqe_type;

endpackage

// >>> design/phymc_sync2.sv
// two flip-flop level synchroniser
`timescale 1ns/10ps
`default_nettype none
module phymc_sync2 #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// levels
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_r;

	generate
		if (W < 1) begin : g_chk
			$error("phymc_sync2: W must be at least 1");
		end
	endgenerate

	// first stage is read only by the second
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= '0;
			q      <= '0;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end
endmodule
`default_nettype wire

// >>> design/phymc_delay.sv
// fixed-depth single-bit delay line
`timescale 1ns/10ps
`default_nettype none
module phymc_delay #(
	parameter int DEPTH = 4
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// pulse in and out
	input  wire logic d,
	output logic      q
);
	logic [DEPTH-1:0] pipe_r;

	generate
		if (DEPTH < 1) begin : g_chk
			$error("phymc_delay: DEPTH must be at least 1");
		end
	endgenerate

	// shift toward the msb, one stage per clock
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pipe_r <= '0;
		end else begin
			pipe_r <= DEPTH'({pipe_r, d});
		end
	end

	assign q = pipe_r[DEPTH-1];
endmodule
`default_nettype wire

// >>> design/phymc_top.sv
// mii carrier sense, collision, heartbeat and reset sequencing for a 10/100 phy
`timescale 1ns/10ps
`default_nettype none
module phymc_top
	import phymc_pkg::*;
#(
	parameter int POR_CYCLES = POR_CYC,
	parameter int INIT_CYCLES = RST_CLK_CYC
) (
	// reference clock and reset
	input  wire logic     ref_clk,
	input  wire logic     rst_n,
	// reset pin from the board
	input  wire logic     hw_reset_low,
	// mode straps
	input  wire logic     speed_100,
	input  wire logic     full_duplex,
	// line side, one bit per line clock
	input  wire logic     line_clk,
	input  wire logic     twisted_pair_receive,
	// mii from the mac
	input  wire logic     tx_en,
	// mii to the mac
	output logic          mii_txclk,
	output logic          mii_rxclk,
	output phymc_stat_type stat,
	output phymc_rx_type  rx,
	// reset status
	output logic          isolate,
	output logic          clk_valid
);
	localparam int CW = $clog2((POR_CYCLES > INIT_CYCLES ? POR_CYCLES : INIT_CYCLES) + 1);
	localparam int LW = $clog2(RST_MIN_CYC + 1);

	generate
		if (POR_CYCLES < 1 || INIT_CYCLES < 1) begin : g_chk
			$error("phymc_top: reset counts must be at least 1");
		end
	endgenerate

	// ****************************************
	// reference domain: reset sequencing
	// ****************************************
	logic          hw_s;
	phymc_rst_type rs_r;
	logic [CW-1:0] tmr_r;
	logic [LW-1:0] low_cnt_r;
	logic          iso_r;
	logic          clk_ok_r;

	phymc_sync2 #(.W(1)) u_pin_sync (
		.clk   (ref_clk),
		.rst_n (rst_n),
		.d     (hw_reset_low),
		.q     (hw_s)
	);

	// length of the current low pulse, saturating
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			low_cnt_r <= '0;
		end else if (hw_s) begin
			low_cnt_r <= '0;
		end else if (low_cnt_r < LW'(RST_MIN_CYC)) begin
			low_cnt_r <= low_cnt_r + 1'b1;
		end
	end

	// power-on wait, then ready; a long enough low pulse restarts init
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rs_r  <= RS_POR;
			tmr_r <= '0;
		end else begin
			unique case (rs_r)
				RS_POR: begin
					if (tmr_r == CW'(POR_CYCLES - 1)) begin
						rs_r  <= RS_READY;
						tmr_r <= '0;
					end else begin
						tmr_r <= tmr_r + 1'b1;
					end
				end
				RS_READY: begin
					// short glitches never reach the init restart
					if (!hw_s && low_cnt_r == LW'(RST_MIN_CYC - 1)) begin
						rs_r  <= RS_INIT;
						tmr_r <= '0;
					end
				end
				RS_INIT: begin
					if (!hw_s) begin
						tmr_r <= '0;
					end else if (tmr_r == CW'(INIT_CYCLES - 1)) begin
						rs_r  <= RS_READY;
						tmr_r <= '0;
					end else begin
						tmr_r <= tmr_r + 1'b1;
					end
				end
			endcase
		end
	end

	// isolation follows the pin at once, ahead of pulse qualification
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			iso_r    <= 1'b1;
			clk_ok_r <= 1'b0;
		end else begin
			iso_r    <= !hw_s || rs_r != RS_READY;
			clk_ok_r <= hw_s && rs_r == RS_READY;
		end
	end

	assign isolate   = iso_r;
	assign clk_valid = clk_ok_r;

	// ****************************************
	// line domain: clock gating and straps
	// ****************************************
	logic [2:0] lvl_s;
	logic       link_on;
	logic       spd_s;
	logic       half;
	logic [1:0] nib_r;
	logic       txclk_r;

	phymc_sync2 #(.W(3)) u_line_sync (
		.clk   (line_clk),
		.rst_n (rst_n),
		.d     ({clk_ok_r, speed_100, full_duplex}),
		.q     (lvl_s)
	);

	assign link_on = lvl_s[2];
	assign spd_s   = lvl_s[1];
	assign half    = !lvl_s[0];

	// nibble clock is the bit clock over four; held low until ready
	always_ff @(posedge line_clk or negedge rst_n) begin
		if (!rst_n) begin
			nib_r   <= '0;
			txclk_r <= 1'b0;
		end else if (!link_on) begin
			nib_r   <= '0;
			txclk_r <= 1'b0;
		end else begin
			nib_r   <= nib_r + 1'b1;
			txclk_r <= nib_r[0] ^ nib_r[1] ? txclk_r : nib_r == 2'd0;
		end
	end

	assign mii_txclk = txclk_r;
	assign mii_rxclk = txclk_r;

	// ****************************************
	// line domain: transmit carrier loopback
	// ****************************************
	logic [TXCRS_HOLD-1:0] tx_d_r;
	logic                  tx_term;
	logic                  tx_act;

	// history of tx_en stretches crs past the frame end
	always_ff @(posedge line_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_d_r <= '0;
		end else begin
			tx_d_r <= TXCRS_HOLD'({tx_d_r, tx_en && link_on});
		end
	end

	// loopback only in half duplex; full duplex carrier is receive only
	assign tx_term = half && link_on && (tx_en || |tx_d_r);
	assign tx_act  = tx_en || tx_d_r[0];

	// ****************************************
	// line domain: delimiter detection
	// ****************************************
	logic [DLM_BITS-1:0] sr_r;
	logic                sd_det;
	logic                ed_det;
	logic                sd_q;
	logic                ed_q;
	logic                rx_car_r;
	logic                col_rx_r;
	logic                dv_r;
	logic [3:0]          rxd_r;

	function automatic logic pat_hit(input logic [9:0] s, input logic [9:0] p);
		return s == p;
	endfunction

	// newest bit enters the lsb; first delimiter bit ends at the msb
	always_ff @(posedge line_clk or negedge rst_n) begin
		if (!rst_n) begin
			sr_r <= '0;
		end else begin
			sr_r <= DLM_BITS'({sr_r, twisted_pair_receive});
		end
	end

	assign sd_det = link_on && !rx_car_r && pat_hit(sr_r, PAT_JK);
	assign ed_det = link_on && rx_car_r && pat_hit(sr_r, PAT_TR);

	phymc_delay #(.DEPTH(RXD_DLY)) u_sd_dly (
		.clk   (line_clk),
		.rst_n (rst_n),
		.d     (sd_det),
		.q     (sd_q)
	);

	phymc_delay #(.DEPTH(ED_DLY)) u_ed_dly (
		.clk   (line_clk),
		.rst_n (rst_n),
		.d     (ed_det),
		.q     (ed_q)
	);

	// receive carrier and collision span start to delayed end
	always_ff @(posedge line_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_car_r <= 1'b0;
			col_rx_r <= 1'b0;
		end else if (!link_on || ed_q) begin
			rx_car_r <= 1'b0;
			col_rx_r <= 1'b0;
		end else if (sd_det) begin
			rx_car_r <= 1'b1;
			col_rx_r <= tx_act && half;
		end
	end

	// receive nibbles; the delimiter nibble is shown after the pipeline
	always_ff @(posedge line_clk or negedge rst_n) begin
		if (!rst_n) begin
			dv_r  <= 1'b0;
			rxd_r <= NIB_IDLE;
		end else if (!link_on || ed_q) begin
			dv_r  <= 1'b0;
			rxd_r <= NIB_IDLE;
		end else if (sd_q) begin
			dv_r  <= 1'b1;
			rxd_r <= NIB_SD;
		end
	end

	assign rx.dv = dv_r;
	assign rx.d  = rxd_r;

	// ****************************************
	// line domain: heartbeat after each half duplex 10 mb/s frame
	// ****************************************
	phymc_sqe_type sq_r;
	logic [3:0]    sq_cnt_r;
	logic          sqe_mode;

	assign sqe_mode = half && !spd_s && link_on;

	// counts are bit times at 100 ns, so ns figures divide by BIT10_NS
	always_ff @(posedge line_clk or negedge rst_n) begin
		if (!rst_n) begin
			sq_r     <= SQ_IDLE;
			sq_cnt_r <= '0;
		end else if (!sqe_mode) begin
			sq_r     <= SQ_IDLE;
			sq_cnt_r <= '0;
		end else begin
			unique case (sq_r)
				SQ_IDLE: begin
					if (!tx_en && tx_d_r[0]) begin
						sq_r     <= SQ_WAIT;
						sq_cnt_r <= 4'(SQE_DLY_CYC - 1);
					end
				end
				SQ_WAIT: begin
					if (sq_cnt_r == '0) begin
						sq_r     <= SQ_PULSE;
						sq_cnt_r <= 4'(SQE_LEN_CYC - 1);
					end else begin
						sq_cnt_r <= sq_cnt_r - 1'b1;
					end
				end
				SQ_PULSE: begin
					if (sq_cnt_r == '0) begin
						sq_r <= SQ_IDLE;
					end else begin
						sq_cnt_r <= sq_cnt_r - 1'b1;
					end
				end
			endcase
		end
	end

	// ****************************************
	// line domain: mii status outputs
	// ****************************************
	logic crs_r;
	logic col_r;

	// one register stage keeps the status outputs glitch free
	always_ff @(posedge line_clk or negedge rst_n) begin
		if (!rst_n) begin
			crs_r <= 1'b0;
			col_r <= 1'b0;
		end else begin
			crs_r <= link_on && (rx_car_r || tx_term);
			col_r <= link_on && (col_rx_r || sq_r == SQ_PULSE);
		end
	end

	assign stat.crs = crs_r;
	assign stat.col = col_r;

	// ****************************************
	// checks
	// ****************************************
	a_iso_on_pin: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!hw_s |=> iso_r && !clk_ok_r)
		else $error("isolate not raised after reset pin low");
	a_short_pulse_ignored: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(rs_r == RS_READY && low_cnt_r < LW'(RST_MIN_CYC - 1)) |=> rs_r == RS_READY)
		else $error("short reset pulse restarted init");
	a_por_no_clock: assert property (@(posedge ref_clk) disable iff (!rst_n)
		rs_r != RS_READY |=> !clk_ok_r)
		else $error("clock valid before reset complete");
	a_tx_crs_rise: assert property (@(posedge line_clk) disable iff (!rst_n)
		($rose(tx_en) && half && link_on) |=> ##1 crs_r)
		else $error("crs late after tx_en");
	a_tx_crs_fall: assert property (@(posedge line_clk) disable iff (!rst_n)
		($fell(tx_en) && half && !rx_car_r && !sd_det) |-> crs_r ##[1:4] !crs_r)
		else $error("crs drop outside window after tx_en");
	a_rx_crs_rise: assert property (@(posedge line_clk) disable iff (!rst_n)
		sd_det |-> ##2 crs_r)
		else $error("crs not raised after start delimiter");
	a_rx_nibble_start: assert property (@(posedge line_clk) disable iff (!rst_n)
		(sd_det && !ed_q) |-> ##7 (dv_r && rxd_r == NIB_SD))
		else $error("start nibble not shown in time");
	a_col_rise: assert property (@(posedge line_clk) disable iff (!rst_n)
		(sd_det && tx_act && half) |-> ##2 col_r)
		else $error("collision not raised");
	a_crs_release: assert property (@(posedge line_clk) disable iff (!rst_n)
		ed_det |-> rx_car_r[*5] ##1 !rx_car_r)
		else $error("receive carrier release outside window");
	a_col_release: assert property (@(posedge line_clk) disable iff (!rst_n)
		(ed_det && col_rx_r && sq_r != SQ_WAIT) |-> ##6 !col_r || sq_r == SQ_PULSE)
		else $error("collision not released");
	a_sqe_start: assert property (@(posedge line_clk) disable iff (!rst_n)
		(sq_r == SQ_IDLE && sqe_mode && !tx_en && tx_d_r[0]) |-> ##[1:15] col_r)
		else $error("heartbeat late");
	a_sqe_width: assert property (@(posedge line_clk) disable iff (!rst_n)
		($rose(col_r) && sq_r == SQ_PULSE && !col_rx_r) |-> col_r[*8] ##[1:7] !col_r)
		else $error("heartbeat width wrong");

	c_rx_frame: cover property (@(posedge line_clk) disable iff (!rst_n)
		sd_det ##[1:300] ed_det);
	c_collision: cover property (@(posedge line_clk) disable iff (!rst_n)
		$rose(col_rx_r));
	c_heartbeat: cover property (@(posedge line_clk) disable iff (!rst_n)
		$rose(sq_r == SQ_PULSE));
	c_hw_reset: cover property (@(posedge ref_clk) disable iff (!rst_n)
		rs_r == RS_INIT ##1 rs_r == RS_READY);
endmodule
`default_nettype wire

// >>> verif/phymc_mac_model.sv
// mac stand-in that raises transmit enable for counted frames
`timescale 1ns/10ps
`default_nettype none
module phymc_mac_model (
	// clocks and reset
	input  wire logic       line_clk,
	input  wire logic       rst_n,
	input  wire logic       mii_txclk,
	// frame request from the bench
	input  wire logic       go,
	input  wire logic [7:0] len,
	// mii transmit side
	output logic            tx_en,
	output logic            ready
);
	logic       clk_q;
	logic [7:0] cnt;

	// a mac may only trust the transmit clock once it toggles
	always_ff @(posedge line_clk or negedge rst_n) begin
		if (!rst_n) begin
			clk_q <= 1'b0;
			ready <= 1'b0;
		end else begin
			clk_q <= mii_txclk;
			if (clk_q != mii_txclk) ready <= 1'b1;
		end
	end

	// one frame per request, enable held for len bit times
	always_ff @(posedge line_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_en <= 1'b0;
			cnt   <= 8'h00;
		end else if (cnt != 8'h00) begin
			cnt   <= cnt - 8'h01;
			tx_en <= (cnt != 8'h01);
		end else if (go && ready) begin
			tx_en <= 1'b1;
			cnt   <= len;
		end
	end
endmodule
`default_nettype wire

// >>> verif/phymc_top_tb_top.sv
// self-checking bench for the mii carrier and collision block
`timescale 1ns/10ps
`default_nettype none
module phymc_top_tb_top
	import phymc_pkg::*;
;
	localparam int POR_SIM  = 50;
	localparam int INIT_SIM = 40;
	logic           ref_clk, rst_n, hw_reset_low, speed_100, full_duplex;
	logic           line_clk, tpr, tx_en, go, ready;
	logic           mii_txclk, mii_rxclk, isolate, clk_valid;
	logic [7:0]     len;
	logic [31:0]    seed;
	phymc_stat_type stat;
	phymc_rx_type   rx;
	int             err_count, tests_run, n1, n2, n3;

	// unrelated reference and line clocks
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	initial begin
		line_clk = 1'b0;
		#7;
		forever #16 line_clk = ~line_clk;
	end

	phymc_top #(.POR_CYCLES(POR_SIM), .INIT_CYCLES(INIT_SIM)) DUT (
		.ref_clk(ref_clk), .rst_n(rst_n), .hw_reset_low(hw_reset_low),
		.speed_100(speed_100), .full_duplex(full_duplex), .line_clk(line_clk),
		.twisted_pair_receive(tpr), .tx_en(tx_en), .mii_txclk(mii_txclk),
		.mii_rxclk(mii_rxclk), .stat(stat), .rx(rx), .isolate(isolate),
		.clk_valid(clk_valid));

	phymc_mac_model mac (
		.line_clk(line_clk), .rst_n(rst_n), .mii_txclk(mii_txclk),
		.go(go), .len(len), .tx_en(tx_en), .ready(ready));

	// verdict and end of run
	task automatic summarize();
		$display("errors %0d checks %0d", err_count, tests_run);
		if (err_count == 0 && tests_run > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	// xorshift source with a fixed start
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// single comparison point
	task automatic check(input logic [3:0] seen, input logic [3:0] exp, input string msg);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t %s", $time, msg);
		end
	endtask

	// model window: a measured clock-edge count must sit inside lo..hi
	task automatic win(input int n, input int lo, input int hi, input string msg);
		check({3'h0, (n >= lo && n <= hi)}, 4'h1, msg);
	endtask

	function automatic logic cur(input int w);
		case (w)
			0: return stat.crs;
			1: return stat.col;
			2: return rx.dv;
			3: return tx_en;
			4: return isolate;
			default: return clk_valid;
		endcase
	endfunction

	// count edges until a signal reaches a level; running out ends the run
	task automatic wait_for(input int w, input logic lvl, input int lim, output int n);
		n = 0;
		while (cur(w) !== lvl) begin
			if (w > 3) @(posedge ref_clk);
			else @(posedge line_clk);
			#1;
			n++;
			if (n > lim) begin
				err_count++;
				$display("CHECK FAILED t=%0t wait %0d ran out", $time, w);
				summarize();
			end
		end
	endtask

	// ten code bits on the line, first bit first, idle ones after
	task automatic send(input logic [9:0] p);
		for (int i = 9; i >= 0; i--) begin
			@(posedge line_clk);
			tpr <= p[i];
		end
		@(posedge line_clk);
		tpr <= 1'b1;
	endtask

	// ask the mac for one frame; #1 lets its enable land
	task automatic frame(input logic [7:0] l);
		@(posedge line_clk);
		go  <= 1'b1;
		len <= l;
		@(posedge line_clk);
		go  <= 1'b0;
		#1;
	endtask

	// transmit loopback, heartbeat when slow
	task automatic tx_case(input logic fast);
		frame(8'd20 + 8'(rnd() % 30));
		wait_for(3, 1'b1, 4, n1);
		wait_for(0, 1'b1, 20, n1);
		win(n1, 0, fast ? 4 : TXCRS_RISE, "crs rise");
		wait_for(3, 1'b0, 80, n1);
		fork
			wait_for(0, 1'b0, 20, n1);
			if (!fast) wait_for(1, 1'b1, 20, n2);
		join
		win(n1, 0, 4, "crs fall");
		if (!fast) begin
			win(n2, 1, SQE_MAX_NS / BIT10_NS, "sqe start");
			wait_for(1, 1'b0, 20, n3);
			win(n3, 1, SQE_MAX_NS / BIT10_NS, "sqe width");
		end
	endtask

	// received frame at 100, optionally during a transmit
	task automatic rx_case(input logic coll);
		if (coll) frame(8'd90);
		repeat (4) @(posedge line_clk);
		fork
			send(PAT_JK);
			begin
				@(posedge line_clk);
				wait_for(coll ? 1 : 0, 1'b1, 20, n1);
			end
			begin
				@(posedge line_clk);
				wait_for(2, 1'b1, 25, n2);
				check(rx.d, NIB_SD, "start nibble");
			end
		join
		if (coll) win(n1, 9, 13, "col rise");
		else win(n1, 10, 14, "crs rise rx");
		win(n2, 1, 17, "rx latency");
		repeat (4 + rnd() % 20) @(posedge line_clk);
		fork
			send(PAT_TR);
			begin
				@(posedge line_clk);
				wait_for(coll ? 1 : 0, 1'b0, 25, n1);
			end
		join
		if (coll) win(n1, 13, 18, "col release");
		else win(n1, 13, 18, "crs fall rx");
		wait_for(3, 1'b0, 120, n3);
		wait_for(0, 1'b0, 20, n3);
	endtask

	// main sequence
	initial begin
		seed = 32'h5;
		err_count = 0;
		tests_run = 0;
		rst_n = 1'b0;
		hw_reset_low = 1'b1;
		speed_100 = 1'b0;
		full_duplex = 1'b0;
		tpr = 1'b1;
		go = 1'b0;
		len = 8'h00;
		repeat (5) @(posedge ref_clk);
		check(isolate, 1'b1, "isolated in reset");
		check(clk_valid, 1'b0, "no clock in reset");
		rst_n <= 1'b1;
		wait_for(5, 1'b1, POR_SIM + 8, n1);
		win(n1, POR_SIM, POR_SIM + 8, "por length");
		for (int i = 0; i < 60 && ready !== 1'b1; i++) @(posedge line_clk);
		check(ready, 1'b1, "tx clock running");
		check(mii_rxclk, mii_txclk, "rx clock follows tx clock");
		for (int m = 0; m < 6; m++) begin
			@(posedge line_clk);
			speed_100 <= (m > 2);
			repeat (8) @(posedge line_clk);
			tx_case(m > 2);
			repeat (20) @(posedge line_clk);
		end
		rx_case(1'b0);
		rx_case(1'b1);
		@(posedge line_clk);
		full_duplex <= 1'b1;
		speed_100 <= 1'b0;
		repeat (8) @(posedge line_clk);
		frame(8'd30);
		repeat (6) @(posedge line_clk);
		#1;
		check(stat.crs, 1'b0, "loopback in full duplex");
		wait_for(3, 1'b0, 40, n1);
		repeat (12) @(posedge line_clk);
		#1;
		check(stat.col, 1'b0, "sqe in full duplex");
		@(posedge ref_clk);
		hw_reset_low <= 1'b0;
		wait_for(4, 1'b1, 6, n1);
		win(n1, 1, ISO_CYC + 2, "isolate delay");
		repeat (RST_MIN_CYC + 2) @(posedge ref_clk);
		#1;
		check(clk_valid, 1'b0, "clock held in reset");
		check(mii_txclk, 1'b0, "tx clock stopped in reset");
		@(posedge ref_clk);
		hw_reset_low <= 1'b1;
		wait_for(5, 1'b1, INIT_SIM + 8, n1);
		win(n1, INIT_SIM, INIT_SIM + 8, "init length");
		summarize();
	end
endmodule
`default_nettype wire
